// >>> bench/tcm_host.sv
// host processor model driving the parallel port of the switch
`timescale 1ns/1ps
module tcm_host
  import tcm_pkg::*;
(
  input  wire logic              sys_clk,
  output logic      [ADDR_W-1:0] hp_addr,
  output logic                   hp_wr,
  output logic                   hp_rd,
  output logic      [DATA_W-1:0] hp_wdata,
  input  wire logic [DATA_W-1:0] hp_rdata,
  input  wire logic              hp_rvalid,
  input  wire logic              hp_addr_err
);
  // idle port at time zero
  initial
  begin
    hp_addr  = '0;
    hp_wr    = 1'b0;
    hp_rd    = 1'b0;
    hp_wdata = '0;
  end

  // ==========================================
  // one access: strobe held for a single edge, then the released
  // lines show inverted values so a stale bus is never trusted
  task automatic access(input logic wr, input logic mem, input logic [12:0] a, input logic [15:0] d,
                        output logic err, output logic vld, output logic [15:0] q);
    @(posedge sys_clk);
    hp_addr  <= {mem, a};
    hp_wdata <= d;
    hp_wr    <= wr;
    hp_rd    <= !wr;
    // strobe taken at this edge; the error pulse stands only until the next one
    @(posedge sys_clk);
    hp_wr    <= 1'b0;
    hp_rd    <= 1'b0;
    hp_addr  <= ~{mem, a};
    hp_wdata <= ~d;
    #1 err = hp_addr_err;
    // read answer stands one cycle, launched by the first edge after the take
    @(posedge sys_clk);
    #1 vld = hp_rvalid;
    q = hp_rdata;
  endtask : access
endmodule : tcm_host

// >>> bench/tcm_map_tb.sv
// self-checking bench for the connection memory map
`timescale 1ns/1ps
module tcm_map_tb;
  import tcm_pkg::*;
  logic                     sys_clk, rst, hp_wr, hp_rd, hp_rvalid, hp_addr_err, dm_wr, lk_req, lk_valid;
  logic                     lk_normal, lk_companding, lk_variable_delay, var_delay_enable, e, v, ven;
  logic [ADDR_W-1:0]        hp_addr;
  logic [DATA_W-1:0]        hp_wdata, hp_rdata, dm_wdata, lk_conv_method, q, lo, hi;
  logic [2*NUM_STREAMS-1:0] stream_rate, sr;
  logic [MEM_ADDR_W-1:0]    dm_addr;
  logic [STREAM_W-1:0]      lk_stream, lk_src_stream;
  logic [CHAN_W-1:0]        lk_channel, lk_src_channel;
  logic [1:0]               lk_special_mode;
  int                       err_total, checks_done, s, c;

  tcm_map tcm_map_i (.sys_clk, .rst, .hp_addr, .hp_wr, .hp_rd, .hp_wdata, .hp_rdata, .hp_rvalid,
    .hp_addr_err, .stream_rate, .dm_wr, .dm_addr, .dm_wdata, .lk_req, .lk_stream, .lk_channel,
    .lk_valid, .lk_normal, .lk_src_stream, .lk_src_channel, .lk_companding, .lk_conv_method,
    .lk_variable_delay, .lk_special_mode, .var_delay_enable);
  tcm_host tcm_host_i (.sys_clk, .hp_addr, .hp_wr, .hp_rd, .hp_wdata, .hp_rdata, .hp_rvalid, .hp_addr_err);

  // 10 MHz clock
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  // ==========================================
  // helpers
  function automatic int lim(input logic [1:0] r);
    return 32 << r;
  endfunction : lim

  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checks_done++;
    if (g !== x)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic ctl(input logic [15:0] d);
    tcm_host_i.access(1'b1, 1'b0, CTRL_OFFSET, d, e, v, q);
  endtask : ctl

  task automatic mw(input int s, input int c, input logic [15:0] d);
    tcm_host_i.access(1'b1, 1'b1, {s[4:0], c[7:0]}, d, e, v, q);
    chk("wr_no_rvalid", 16'h0000, v);
  endtask : mw

  task automatic mr(input int s, input int c);
    tcm_host_i.access(1'b0, 1'b1, {s[4:0], c[7:0]}, 16'h0000, e, v, q);
    chk("rd_rvalid", 16'h0001, v);
  endtask : mr

  // lookup: result stands between the first and second edge after the take
  task automatic look(input int s, input int c);
    @(posedge sys_clk);
    lk_req     <= 1'b1;
    lk_stream  <= s[4:0];
    lk_channel <= c[7:0];
    @(posedge sys_clk);
    lk_req     <= 1'b0;
    lk_stream  <= ~s[4:0];
    lk_channel <= ~c[7:0];
    @(posedge sys_clk);
    #1 chk("lk_valid", 16'h0001, lk_valid);
    chk("lk_normal", !lo[0], lk_normal);
    chk("lk_src", {lo[13:9], lo[8:1]}, {lk_src_stream, lk_src_channel});
    chk("lk_comp", lo[15], lk_companding);
    chk("lk_conv", lo[15] ? hi : 16'h0000, lk_conv_method);
    chk("lk_vdel", lo[14] & ven, lk_variable_delay);
    chk("lk_spec", lo[0] ? lo[2:1] : 2'h0, lk_special_mode);
  endtask : look

  // watchdog: the tests need well under 6000 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    report_and_stop();
  end

  // ==========================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    stream_rate = '0;
    dm_wr = 1'b0;
    dm_addr = '0;
    dm_wdata = '0;
    lk_req = 1'b0;
    lk_stream = '0;
    lk_channel = '0;
    err_total = 0;
    checks_done = 0;
    void'($urandom(60504));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    tcm_host_i.access(1'b0, 1'b0, CTRL_OFFSET, 16'h0000, e, v, q);
    chk("ctrl_reset", CTRL_RESET, q);
    chk("reg_rvalid", 16'h0001, v);
    ctl(16'hFFFF);
    tcm_host_i.access(1'b0, 1'b0, CTRL_OFFSET, 16'h0000, e, v, q);
    chk("ctrl_mask", CTRL_MASK, q);
    chk("var_en", 16'h0001, var_delay_enable);
    tcm_host_i.access(1'b0, 1'b0, 13'h0005, 16'h0000, e, v, q);
    chk("unmapped", 16'h0000, q);
    $display("test registers done");
    // host writes to data memory are dropped, core writes are seen
    ctl({14'h0000, SEL_DATA});
    @(posedge sys_clk);
    dm_wr <= 1'b1;
    dm_addr <= 13'h0105;
    dm_wdata <= 16'hA5C3;
    @(posedge sys_clk);
    dm_wr <= 1'b0;
    mw(1, 5, 16'h1111);
    mr(1, 5);
    chk("data_mem", 16'hA5C3, q);
    ctl({14'h0000, SEL_LOW});
    mw(1, 5, 16'h2222);
    tcm_host_i.access(1'b1, 1'b0, 13'h0105, 16'h3333, e, v, q);
    mr(1, 5);
    chk("low_word", 16'h2222, q);
    ctl({14'h0000, 2'h3});
    chk("var_dis", 16'h0000, var_delay_enable);
    mr(1, 5);
    chk("sel3_err", 16'h0001, e);
    chk("sel3_data", 16'h0000, q);
    $display("test select done");
    // channel bounds per rate: last legal channel and the next one, illegal except at the top rate where it wraps to channel 0
    ctl({14'h0000, SEL_LOW});
    @(posedge sys_clk);
    stream_rate <= 64'h0000_0000_0000_00E4;
    for (int r = 0; r < 4; r++)
    begin
      mw(r, lim(r) - 1, 16'h0F0F ^ r);
      chk("edge_err", 16'h0000, e);
      mr(r, lim(r) - 1);
      chk("edge_rd", 16'h0F0F ^ r, q);
      mw(r, lim(r), 16'hFFFF);
      chk("over_err", r < 3, e);
      mr(r, lim(r));
      chk("over_rd_err", r < 3, e);
      chk("over_rd", (r < 3) ? 16'h0000 : 16'hFFFF, q);
    end
    $display("test bounds done");
    // random connections, every mode code walked through by the low bits
    sr = {$urandom, $urandom};
    @(posedge sys_clk);
    stream_rate <= sr;
    for (int i = 0; i < 32; i++)
    begin
      s = $urandom_range(31);
      c = $urandom_range(lim(sr[2*s +: 2]) - 1);
      hi = $urandom;
      lo = $urandom;
      ven = $urandom;
      lo[2:0] = i[2:0];
      lo[15] = i[3];
      lo[14] = i[4] & ven;
      ctl({13'h0000, ven, SEL_HIGH});
      mw(s, c, hi);
      mr(s, c);
      chk("high_rd", hi, q);
      ctl({13'h0000, ven, SEL_LOW});
      mw(s, c, lo);
      mr(s, c);
      chk("low_rd", lo, q);
      look(s, c);
    end
    $display("test lookup done");
    report_and_stop();
  end
endmodule : tcm_map_tb

// >>> hdl/tcm_map.sv
// host port decode, connection memories and connection word decode
`timescale 1ns/1ps
module tcm_map
  import tcm_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic [ADDR_W-1:0]         hp_addr,
  input  wire logic                      hp_wr,
  input  wire logic                      hp_rd,
  input  wire logic [DATA_W-1:0]         hp_wdata,
  output logic      [DATA_W-1:0]         hp_rdata,
  output logic                           hp_rvalid,
  output logic                           hp_addr_err,
  input  wire logic [2*NUM_STREAMS-1:0]  stream_rate,
  input  wire logic                      dm_wr,
  input  wire logic [MEM_ADDR_W-1:0]     dm_addr,
  input  wire logic [DATA_W-1:0]         dm_wdata,
  input  wire logic                      lk_req,
  input  wire logic [STREAM_W-1:0]       lk_stream,
  input  wire logic [CHAN_W-1:0]         lk_channel,
  output logic                           lk_valid,
  output logic                           lk_normal,
  output logic      [STREAM_W-1:0]       lk_src_stream,
  output logic      [CHAN_W-1:0]         lk_src_channel,
  output logic                           lk_companding,
  output logic      [DATA_W-1:0]         lk_conv_method,
  output logic                           lk_variable_delay,
  output logic      [1:0]                lk_special_mode,
  output logic                           var_delay_enable
);
  // =====================================================
  // state
  typedef struct packed {
    logic [DATA_W-1:0]   ctrl;
    logic                rd_pend;
    logic                rd_mem;
    logic                rd_bad;
    logic [1:0]          rd_sel;
    logic [DATA_W-1:0]   rd_reg;
    logic [DATA_W-1:0]   rdata;
    logic                rvalid;
    logic                err;
    logic                lk_pend;
    logic                lk_valid;
    logic                normal;
    logic [STREAM_W-1:0] src_st;
    logic [CHAN_W-1:0]   src_ch;
    logic                cmp;
    logic [DATA_W-1:0]   method;
    logic                vdel;
    logic [1:0]          spec;
  } tcm_state_t;

  tcm_state_t st_q;
  tcm_state_t st_d;

  tcm_mem_if #(.AW(MEM_ADDR_W), .DW(DATA_W)) dm_if ();
  tcm_mem_if #(.AW(MEM_ADDR_W), .DW(DATA_W)) lo_if ();
  tcm_mem_if #(.AW(MEM_ADDR_W), .DW(DATA_W)) hi_if ();

  // =====================================================
  // decode helpers
  // channel legal for the stream rate
  function automatic logic chan_ok(input logic [1:0] rate, input logic [CHAN_W-1:0] ch);
    case (tcm_rate_t'(rate))
      TCM_RATE_2M: chan_ok = (ch[7:5] == 3'h0);
      TCM_RATE_4M: chan_ok = (ch[7:6] == 2'h0);
      TCM_RATE_8M: chan_ok = (ch[7] == 1'b0);
      default:     chan_ok = 1'b1;
    endcase
  endfunction : chan_ok

  logic [STREAM_W-1:0] hp_stream;
  logic [1:0]          hp_rate;
  logic                mem_space;
  logic                addr_ok;
  logic [1:0]          sel;
  logic                sel_ok;

  assign hp_stream = hp_addr[STREAM_LSB +: STREAM_W];
  assign hp_rate   = stream_rate[2*hp_stream +: 2];
  assign mem_space = hp_addr[SPACE_BIT];
  assign addr_ok   = chan_ok(hp_rate, hp_addr[CHAN_W-1:0]);
  assign sel       = st_q.ctrl[CTRL_SEL_LSB +: 2];
  assign sel_ok    = (sel != 2'h3);

  // =====================================================
  // memory ports: host on port a, switch core on port b
  always_comb
  begin
    dm_if.a_en    = hp_rd && mem_space && addr_ok && (sel == SEL_DATA);
    dm_if.a_we    = 1'b0;  // data memory is filled by the core only
    dm_if.a_addr  = hp_addr[MEM_ADDR_W-1:0];
    dm_if.a_wdata = hp_wdata;
    dm_if.b_en    = dm_wr;
    dm_if.b_we    = dm_wr;
    dm_if.b_addr  = dm_addr;
    dm_if.b_wdata = dm_wdata;
    lo_if.a_en    = (hp_rd || hp_wr) && mem_space && addr_ok && (sel == SEL_LOW);
    lo_if.a_we    = hp_wr;
    lo_if.a_addr  = hp_addr[MEM_ADDR_W-1:0];
    lo_if.a_wdata = hp_wdata;
    lo_if.b_en    = lk_req;
    lo_if.b_we    = 1'b0;
    lo_if.b_addr  = {lk_stream, lk_channel};
    lo_if.b_wdata = '0;
    hi_if.a_en    = (hp_rd || hp_wr) && mem_space && addr_ok && (sel == SEL_HIGH);
    hi_if.a_we    = hp_wr;
    hi_if.a_addr  = hp_addr[MEM_ADDR_W-1:0];
    hi_if.a_wdata = hp_wdata;
    hi_if.b_en    = lk_req;
    hi_if.b_we    = 1'b0;
    hi_if.b_addr  = {lk_stream, lk_channel};
    hi_if.b_wdata = '0;
  end

  tcm_mem #(.AW(MEM_ADDR_W), .DW(DATA_W)) u_data (.sys_clk(sys_clk), .mif(dm_if));
  tcm_mem #(.AW(MEM_ADDR_W), .DW(DATA_W)) u_low  (.sys_clk(sys_clk), .mif(lo_if));
  tcm_mem #(.AW(MEM_ADDR_W), .DW(DATA_W)) u_high (.sys_clk(sys_clk), .mif(hi_if));

  // =====================================================
  // next state: control register, read pipeline, lookup decode
  always_comb
  begin
    st_d          = st_q;
    st_d.rvalid   = 1'b0;
    st_d.lk_valid = 1'b0;
    st_d.err      = (hp_wr || hp_rd) && mem_space && !(addr_ok && sel_ok);
    // register space write; only bits 2..0 exist, the rest hold zero
    if (hp_wr && !mem_space && hp_addr[MEM_ADDR_W-1:0] == CTRL_OFFSET)
      st_d.ctrl = hp_wdata & CTRL_MASK;
    // read stage one: capture the target, memory answers next cycle
    st_d.rd_pend = hp_rd;
    st_d.rd_mem  = mem_space;
    st_d.rd_bad  = mem_space && !(addr_ok && sel_ok);
    st_d.rd_sel  = sel;
    st_d.rd_reg  = (hp_addr[MEM_ADDR_W-1:0] == CTRL_OFFSET) ? st_q.ctrl : '0;
    // read stage two: pick the answer
    if (st_q.rd_pend)
    begin
      st_d.rvalid = 1'b1;
      if (!st_q.rd_mem)
        st_d.rdata = st_q.rd_reg;
      else if (st_q.rd_bad)
        st_d.rdata = '0;
      else
        case (st_q.rd_sel)
          SEL_DATA: st_d.rdata = dm_if.a_rdata;
          SEL_LOW:  st_d.rdata = lo_if.a_rdata;
          SEL_HIGH: st_d.rdata = hi_if.a_rdata;
          default:  st_d.rdata = '0;
        endcase
    end
    // lookup: words arrive one cycle after the request
    st_d.lk_pend = lk_req;
    if (st_q.lk_pend)
    begin
      st_d.lk_valid = 1'b1;
      st_d.normal   = !lo_if.b_rdata[CW_MODE_BIT];
      st_d.src_st   = lo_if.b_rdata[CW_STREAM_LSB +: STREAM_W];
      st_d.src_ch   = lo_if.b_rdata[CW_CHAN_LSB +: CHAN_W];
      st_d.cmp      = lo_if.b_rdata[CW_CONV_BIT];
      // high word only matters when conversion is on
      st_d.method   = lo_if.b_rdata[CW_CONV_BIT] ? hi_if.b_rdata : '0;
      // variable delay is gated by the global enable, guarding a host that skipped it
      st_d.vdel     = lo_if.b_rdata[CW_VDEL_BIT] && st_q.ctrl[VAR_EN_BIT];
      st_d.spec     = lo_if.b_rdata[CW_MODE_BIT] ? lo_if.b_rdata[CW_SPEC_LSB +: 2] : SPEC_TRISTATE;
    end
  end

  // =====================================================
  // state register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_q      <= '0;
      st_q.ctrl <= CTRL_RESET;
    end
    else
      st_q <= st_d;
  end

  // outputs straight from the state register
  assign hp_rdata          = st_q.rdata;
  assign hp_rvalid         = st_q.rvalid;
  assign hp_addr_err       = st_q.err;
  assign lk_valid          = st_q.lk_valid;
  assign lk_normal         = st_q.normal;
  assign lk_src_stream     = st_q.src_st;
  assign lk_src_channel    = st_q.src_ch;
  assign lk_companding     = st_q.cmp;
  assign lk_conv_method    = st_q.method;
  assign lk_variable_delay = st_q.vdel;
  assign lk_special_mode   = st_q.spec;
  assign var_delay_enable  = st_q.ctrl[VAR_EN_BIT];

  // =====================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_mem_read;
    hp_rd && mem_space && addr_ok && sel_ok && !hp_wr;
  endsequence

  a_mem_space_write: assert property (hp_wr && mem_space && addr_ok && sel == SEL_LOW |-> lo_if.a_en && lo_if.a_we)
    else $error("memory space write missed low word bank");
  a_reg_space_only: assert property (!mem_space |-> !lo_if.a_en && !hi_if.a_en && !dm_if.a_en)
    else $error("register space access reached a memory");
  a_ctrl_write: assert property (hp_wr && !mem_space && hp_addr[12:0] == CTRL_OFFSET |=> st_q.ctrl == ($past(hp_wdata) & CTRL_MASK))
    else $error("control register write not stored");
  a_sel_high_bank: assert property (hp_wr && mem_space && addr_ok && sel == SEL_HIGH |-> hi_if.a_we && hi_if.a_en && !lo_if.a_en)
    else $error("high word select wrong bank");
  a_addr_fields: assert property (lo_if.a_en |-> lo_if.a_addr == {hp_addr[12:8], hp_addr[7:0]})
    else $error("stream or channel field misplaced");
  a_rate_refuse: assert property (hp_wr && mem_space && !addr_ok |-> !lo_if.a_en && !hi_if.a_en ##1 hp_addr_err)
    else $error("out of range channel not refused");
  a_src_fields: assert property (lk_valid && lk_normal |-> lk_src_stream == $past(lo_if.b_rdata[13:9]) && lk_src_channel == $past(lo_if.b_rdata[8:1]))
    else $error("source fields decoded wrong");
  a_mode_bit: assert property (lk_req ##1 1'b1 |=> lk_valid && lk_normal == !$past(lo_if.b_rdata[0]))
    else $error("switching mode decode wrong");
  a_conv_ignore: assert property (lk_valid && !lk_companding |-> lk_conv_method == '0)
    else $error("high word used without conversion");
  a_conv_method: assert property (lk_valid && lk_companding |-> lk_conv_method == $past(hi_if.b_rdata))
    else $error("conversion method not from high word");
  a_delay_path: assert property (lk_valid |-> lk_variable_delay == ($past(lo_if.b_rdata[14]) && $past(st_q.ctrl[2])))
    else $error("delay path decode wrong");
  a_special_mode: assert property (lk_valid && !lk_normal |-> lk_special_mode == $past(lo_if.b_rdata[2:1]))
    else $error("special mode field wrong");
  a_cm_readback: assert property (s_mem_read and (sel == SEL_LOW) |-> ##2 hp_rvalid && hp_rdata == $past(lo_if.a_rdata))
    else $error("connection word read back wrong");
endmodule : tcm_map

// >>> hdl/tcm_mem.sv
// two-port memory bank with registered read data
`timescale 1ns/1ps
module tcm_mem #(
  parameter int AW = 13,
  parameter int DW = 16
) (
  input  wire logic sys_clk,
  tcm_mem_if.mem    mif
);
  logic [DW-1:0] store [0:(1<<AW)-1];
  logic [DW-1:0] a_rdata_q;
  logic [DW-1:0] b_rdata_q;

  // =====================================================
  // storage: each port reads old data on a same-cycle write
  always_ff @(posedge sys_clk)
  begin
    if (mif.a_en && mif.a_we)
      store[mif.a_addr] <= mif.a_wdata;
    if (mif.b_en && mif.b_we)
      store[mif.b_addr] <= mif.b_wdata;
    if (mif.a_en)
      a_rdata_q <= store[mif.a_addr];
    if (mif.b_en)
      b_rdata_q <= store[mif.b_addr];
  end

  assign mif.a_rdata = a_rdata_q;
  assign mif.b_rdata = b_rdata_q;
endmodule : tcm_mem

// >>> shared/tcm_mem_if.sv
// carrier between the map logic and one memory bank
`timescale 1ns/1ps
interface tcm_mem_if #(parameter int AW = 13, parameter int DW = 16);
  logic          a_en;
  logic          a_we;
  logic [AW-1:0] a_addr;
  logic [DW-1:0] a_wdata;
  logic [DW-1:0] a_rdata;
  logic          b_en;
  logic          b_we;
  logic [AW-1:0] b_addr;
  logic [DW-1:0] b_wdata;
  logic [DW-1:0] b_rdata;
  modport user (output a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata, input a_rdata, b_rdata);
  modport mem  (input a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata, output a_rdata, b_rdata);
endinterface : tcm_mem_if

// >>> shared/tcm_pkg.sv
// constants and types shared by the connection memory map block
package tcm_pkg;
  // address layout of the host port
  localparam int ADDR_W        = 14;
  localparam int SPACE_BIT     = 13;
  localparam int MEM_ADDR_W    = 13;
  localparam int STREAM_LSB    = 8;
  localparam int STREAM_W      = 5;
  localparam int CHAN_W        = 8;
  localparam int DATA_W        = 16;
  localparam int NUM_STREAMS   = 32;
  // internal register space
  localparam logic [12:0] CTRL_OFFSET = 13'h0000;
  localparam int CTRL_SEL_LSB  = 0;
  localparam int VAR_EN_BIT    = 2;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] CTRL_MASK   = 16'h0007;
  // memory select codes in control bits 1..0
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_LOW  = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  // low connection word fields
  localparam int CW_MODE_BIT   = 0;
  localparam int CW_CHAN_LSB   = 1;
  localparam int CW_STREAM_LSB = 9;
  localparam int CW_VDEL_BIT   = 14;
  localparam int CW_CONV_BIT   = 15;
  localparam int CW_SPEC_LSB   = 1;
  // per-stream rate codes
  typedef enum logic [1:0] {TCM_RATE_2M, TCM_RATE_4M, TCM_RATE_8M, TCM_RATE_16M} tcm_rate_t;
  // special per-channel modes
  localparam logic [1:0] SPEC_TRISTATE = 2'h0;
  localparam logic [1:0] SPEC_MESSAGE  = 2'h1;
  localparam logic [1:0] SPEC_BER      = 2'h2;
  // read pipeline latency in cycles from request to valid
  localparam int RD_LATENCY    = 2;
endpackage : tcm_pkg
